// File: inc/fdc_pkg.sv
package fdc_pkg;
	localparam logic [6:0] SLAVE_ADDR    = 7'h53;
	localparam logic [7:0] ADDR_ENABLE   = 8'h10;
	localparam logic [7:0] ADDR_PRIVACY  = 8'h11;
	localparam logic [7:0] ADDR_IND      = 8'h12;
	localparam logic [7:0] ADDR_BLINK    = 8'h13;
	localparam logic [7:0] ADDR_PWM      = 8'h14;
	localparam logic [7:0] ADDR_PINFN    = 8'h20;
	localparam logic [7:0] ADDR_VMON     = 8'h30;
	localparam logic [7:0] ADDR_CDELAY   = 8'h31;
	localparam logic [7:0] ADDR_SUPPLY   = 8'h80;
	localparam logic [7:0] ADDR_LAST     = 8'h81;
	localparam logic [7:0] ADDR_TORCH    = 8'hA0;
	localparam logic [7:0] ADDR_FLASH    = 8'hB0;
	localparam logic [7:0] ADDR_TIMEOUT  = 8'hC0;
	localparam logic [7:0] ADDR_FLAGS    = 8'hD0;
	localparam logic [7:0] ADDR_CFG1     = 8'hE0;
	localparam logic [7:0] ADDR_CFG2     = 8'hF0;
	localparam logic [7:0] RST_ENABLE    = 8'h18;
	localparam logic [7:0] RST_PRIVACY   = 8'h58;
	localparam logic [7:0] RST_ZERO      = 8'h00;
	localparam logic [7:0] RST_PWM       = 8'hF8;
	localparam logic [7:0] RST_PINFN     = 8'h80;
	localparam logic [7:0] RST_VMON      = 8'h80;
	localparam logic [7:0] RST_CDELAY    = 8'h90;
	localparam logic [7:0] RST_SUPPLY    = 8'hC0;
	localparam logic [7:0] RST_TORCH     = 8'h52;
	localparam logic [7:0] RST_FLASH     = 8'hDD;
	localparam logic [7:0] RST_TIMEOUT   = 8'hEF;
	localparam logic [7:0] RST_CFG1      = 8'h6B;
	localparam logic [7:0] RST_CFG2      = 8'hE0;
	// Field positions.
	localparam int EN_MODE_LO    = 0;
	localparam int EN_PRIV_PEAK  = 2;
	localparam int EN_SRC_ONE    = 3;
	localparam int EN_SRC_TWO    = 4;
	localparam int EN_EDGE       = 5;
	localparam int EN_MSG        = 6;
	localparam int EN_BLINK      = 7;
	localparam int CFG1_THERM    = 4;
	localparam int CFG2_THERM_SD = 1;
	localparam int CFG2_AET      = 2;
	localparam int VMON_EOC      = 6;
	localparam int VMON_MANUAL   = 7;
	localparam int VMON_ADC_EN   = 5;
	localparam int FLAG_TIMEOUT  = 0;
	localparam int FLAG_THERM    = 3;
	localparam logic [1:0] MODE_OFF     = 2'b00;
	localparam logic [1:0] MODE_PRIVACY = 2'b01;
	localparam logic [1:0] MODE_TORCH   = 2'b10;
	localparam logic [1:0] MODE_FLASH   = 2'b11;
	// Timing.
	localparam int CLK_MHZ        = 250;
	localparam int DEGLITCH_US    = 250;
	localparam int DEGLITCH_CYC   = DEGLITCH_US * CLK_MHZ;
	localparam int CONV_CYC       = 64;
	localparam int FLASH_CYC      = 250000;
	localparam int SCL_HALF_CYC   = 10;
endpackage : fdc_pkg

// File: inc/fdc_link_if.sv
`timescale 1ns/1ns
interface fdc_link_if;
	logic scl;
	logic sda_master_out;
	logic sda_master_oe;
	logic sda_dev_out;
	logic sda_dev_oe;
	logic sda;
	// Open drain wire with pull-up.
	assign sda = (sda_master_oe && !sda_master_out) ||
		(sda_dev_oe && !sda_dev_out) ? 1'b0 : 1'b1;
	modport device (input scl, input sda, output sda_dev_out,
		output sda_dev_oe);
	modport master (output scl, input sda, output sda_master_out,
		output sda_master_oe);
endinterface : fdc_link_if

// File: design/fdc_device.sv
`timescale 1ns/1ns
module fdc_device #(
	parameter int DEGLITCH_CYC = fdc_pkg::DEGLITCH_CYC,
	parameter int FLASH_CYC    = fdc_pkg::FLASH_CYC
) (
	// Clock and reset
	input  wire logic       clock_in,
	input  wire logic       rst_in,
	// Link
	fdc_link_if.device      link,
	// Device pins
	input  wire logic       trigger_in,
	input  wire logic       torch_sync_input_in,
	input  wire logic       comparator_trip_in,
	// Status to analog
	output logic [1:0]      led_mode_out,
	output logic            current_source_one_out,
	output logic            current_source_two_out,
	output logic            privacy_peak_out,
	output logic            indicator_on_out,
	output logic            indicator_blink_out,
	output logic            thermistor_mode_out
);
	typedef enum {S_IDLE, S_ADDR, S_REG, S_DATA, S_READ, S_ACK,
		S_RACK, S_IGNORE} fdc_dev_st_type;
	typedef struct packed {
		logic [2:0]  scl_s;
		logic [2:0]  sda_s;
		logic [1:0]  trig_s;
		logic [1:0]  sync_s;
		logic [1:0]  trip_s;
		logic        trig_d;
		logic        sync_d;
		fdc_dev_st_type st;
		fdc_dev_st_type after_ack;
		logic [3:0]  bits;
		logic [7:0]  shift;
		logic [7:0]  ptr;
		logic        rw;
		logic        sda_oe;
		logic [0:15][7:0] regs;
		logic [31:0] deglitch;
		logic        therm_hold;
		logic [31:0] ftimer;
		logic        flashing;
		logic        aet_torch;
		logic        aet_int;
		logic [7:0]  conv;
		logic [1:0]  mode_o;
		logic        s1_o;
		logic        s2_o;
		logic        peak_o;
		logic        ind_o;
		logic        blink_o;
		logic        therm_o;
		logic        sda_o;
	} fdc_dev_state_type;
	fdc_dev_state_type st_r, st_nxt;

	function automatic logic [3:0] idx(input logic [7:0] a);
		case (a)
			fdc_pkg::ADDR_ENABLE:  idx = 4'h0;
			fdc_pkg::ADDR_PRIVACY: idx = 4'h1;
			fdc_pkg::ADDR_IND:     idx = 4'h2;
			fdc_pkg::ADDR_BLINK:   idx = 4'h3;
			fdc_pkg::ADDR_PWM:     idx = 4'h4;
			fdc_pkg::ADDR_PINFN:   idx = 4'h5;
			fdc_pkg::ADDR_VMON:    idx = 4'h6;
			fdc_pkg::ADDR_CDELAY:  idx = 4'h7;
			fdc_pkg::ADDR_SUPPLY:  idx = 4'h8;
			fdc_pkg::ADDR_LAST:    idx = 4'h9;
			fdc_pkg::ADDR_TORCH:   idx = 4'hA;
			fdc_pkg::ADDR_FLASH:   idx = 4'hB;
			fdc_pkg::ADDR_TIMEOUT: idx = 4'hC;
			fdc_pkg::ADDR_FLAGS:   idx = 4'hD;
			fdc_pkg::ADDR_CFG1:    idx = 4'hE;
			fdc_pkg::ADDR_CFG2:    idx = 4'hF;
			default:               idx = 4'hF;
		endcase
	endfunction : idx

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == fdc_pkg::ADDR_CFG2) || (idx(a) != 4'hF);
	endfunction : mapped

	localparam logic [0:15][7:0] RESETS = '{fdc_pkg::RST_ENABLE,
		fdc_pkg::RST_PRIVACY, fdc_pkg::RST_ZERO, fdc_pkg::RST_ZERO,
		fdc_pkg::RST_PWM, fdc_pkg::RST_PINFN, fdc_pkg::RST_VMON,
		fdc_pkg::RST_CDELAY, fdc_pkg::RST_SUPPLY, fdc_pkg::RST_ZERO,
		fdc_pkg::RST_TORCH, fdc_pkg::RST_FLASH, fdc_pkg::RST_TIMEOUT,
		fdc_pkg::RST_ZERO, fdc_pkg::RST_CFG1, fdc_pkg::RST_CFG2};

	logic scl_rise, scl_fall, start_c, stop_c, sda_v, scl_v;
	logic trig_rise, sync_rise, therm_on, trip_q, rd_flags, rd_vmon;
	logic wr_vmon_manual, flash_start, flash_on;
	logic [7:0] en, c2;
	always_comb begin
		st_nxt = st_r;
		scl_v = st_r.scl_s[1];
		sda_v = st_r.sda_s[1];
		scl_rise = scl_v && !st_r.scl_s[2];
		scl_fall = !scl_v && st_r.scl_s[2];
		start_c = scl_v && st_r.scl_s[2] && !sda_v && st_r.sda_s[2];
		stop_c = scl_v && st_r.scl_s[2] && sda_v && !st_r.sda_s[2];
		en = st_r.regs[0];
		c2 = st_r.regs[15];
		rd_flags = 1'b0;
		rd_vmon = 1'b0;
		wr_vmon_manual = 1'b0;
		st_nxt.scl_s = {st_r.scl_s[1:0], link.scl};
		st_nxt.sda_s = {st_r.sda_s[1:0], link.sda};
		st_nxt.trig_s = {st_r.trig_s[0], trigger_in};
		st_nxt.sync_s = {st_r.sync_s[0], torch_sync_input_in};
		st_nxt.trip_s = {st_r.trip_s[0], comparator_trip_in};
		st_nxt.trig_d = st_r.trig_s[1];
		st_nxt.sync_d = st_r.sync_s[1];
		trig_rise = st_r.trig_s[1] && !st_r.trig_d;
		sync_rise = st_r.sync_s[1] && !st_r.sync_d;
		// Serial slave; a start anywhere restarts the address phase.
		if (start_c) begin
			st_nxt.st = S_ADDR;
			st_nxt.bits = 4'd0;
			st_nxt.sda_oe = 1'b0;
		end else if (stop_c) begin
			st_nxt.st = S_IDLE;
			st_nxt.sda_oe = 1'b0;
		end else begin
			case (st_r.st)
				S_ADDR, S_REG, S_DATA: begin
					if (scl_rise) begin
						st_nxt.shift = {st_r.shift[6:0], sda_v};
						st_nxt.bits = st_r.bits + 4'd1;
					end
					if (scl_fall && st_r.bits == 4'd8) begin
						st_nxt.bits = 4'd0;
						st_nxt.st = S_ACK;
						st_nxt.sda_oe = 1'b1;
						if (st_r.st == S_ADDR) begin
							st_nxt.rw = st_r.shift[0];
							if (st_r.shift[7:1] != fdc_pkg::SLAVE_ADDR) begin
								st_nxt.st = S_IGNORE;
								st_nxt.sda_oe = 1'b0;
							end
							st_nxt.after_ack = st_r.shift[0] ? S_READ : S_REG;
						end else if (st_r.st == S_REG) begin
							st_nxt.ptr = st_r.shift;
							st_nxt.after_ack = S_DATA;
						end else begin
							if (mapped(st_r.ptr) && st_r.ptr != fdc_pkg::ADDR_FLAGS) begin
								st_nxt.regs[idx(st_r.ptr)] = st_r.shift;
								// The done bit is status that software cannot set.
								if (st_r.ptr == fdc_pkg::ADDR_VMON) begin
									st_nxt.regs[6][fdc_pkg::VMON_EOC] =
										st_r.regs[6][fdc_pkg::VMON_EOC];
									wr_vmon_manual =
										st_r.shift[fdc_pkg::VMON_MANUAL];
								end
							end
							st_nxt.ptr = st_r.ptr + 8'd1;
							st_nxt.after_ack = S_DATA;
						end
					end
				end
				S_ACK: if (scl_fall) begin
					st_nxt.sda_oe = 1'b0;
					st_nxt.st = st_r.after_ack;
					if (st_r.after_ack == S_READ) begin
						st_nxt.shift = mapped(st_r.ptr) ? st_r.regs[idx(st_r.ptr)]
							: 8'h00;
						st_nxt.sda_oe = 1'b1;
						rd_flags = st_r.ptr == fdc_pkg::ADDR_FLAGS;
						rd_vmon = st_r.ptr == fdc_pkg::ADDR_VMON;
					end
				end
				S_READ: begin
					if (scl_fall) begin
						st_nxt.bits = st_r.bits + 4'd1;
						st_nxt.shift = {st_r.shift[6:0], 1'b0};
						if (st_r.bits == 4'd7) begin
							st_nxt.sda_oe = 1'b0;
							st_nxt.st = S_RACK;
						end
					end
				end
				S_RACK: if (scl_rise) begin
					st_nxt.bits = 4'd0;
					st_nxt.ptr = st_r.ptr + 8'd1;
					st_nxt.st = sda_v ? S_IGNORE : S_ACK;
					st_nxt.after_ack = S_READ;
				end
				default: ;
			endcase
		end
		// Thermistor comparator de-glitch.
		therm_on = st_r.regs[14][fdc_pkg::CFG1_THERM];
		trip_q = 1'b0;
		if (therm_on && st_r.trip_s[1]) begin
			if (st_r.deglitch < 32'(DEGLITCH_CYC - 1))
				st_nxt.deglitch = st_r.deglitch + 32'd1;
			else
				trip_q = 1'b1;
		end else
			st_nxt.deglitch = 32'd0;
		if (trip_q && !st_r.therm_hold) begin
			st_nxt.therm_hold = 1'b1;
		end
		// Set wins over the read clear.
		if (rd_flags)
			st_nxt.regs[13] = 8'h00;
		if (trip_q)
			st_nxt.regs[13][fdc_pkg::FLAG_THERM] = 1'b1;
		if (rd_flags && !st_r.trip_s[1] && !trip_q)
			st_nxt.therm_hold = 1'b0;
		// Flash sequencing.
		flash_start = 1'b0;
		if (en[1:0] == fdc_pkg::MODE_FLASH && trig_rise && !st_r.flashing) begin
			flash_start = 1'b1;
			st_nxt.flashing = 1'b1;
			st_nxt.ftimer = 32'd0;
			st_nxt.aet_int = 1'b0;
			st_nxt.aet_torch = c2[fdc_pkg::CFG2_AET] && st_r.sync_s[1];
		end else if (st_r.flashing) begin
			if (!st_r.aet_torch)
				st_nxt.ftimer = st_r.ftimer + 32'd1;
			if (c2[fdc_pkg::CFG2_AET] && sync_rise)
				st_nxt.aet_int = 1'b1;
			if ((!st_r.aet_torch && st_r.ftimer >= 32'(FLASH_CYC - 1)) ||
				(!en[fdc_pkg::EN_EDGE] && !st_r.trig_s[1]) ||
				en[1:0] != fdc_pkg::MODE_FLASH) begin
				st_nxt.flashing = 1'b0;
				st_nxt.aet_torch = 1'b0;
				if (!st_r.aet_torch && st_r.ftimer >= 32'(FLASH_CYC - 1)) begin
					st_nxt.regs[0][1:0] = fdc_pkg::MODE_OFF;
					st_nxt.regs[13][fdc_pkg::FLAG_TIMEOUT] = 1'b1;
				end
			end
		end
		flash_on = st_r.flashing && !st_r.aet_torch && !st_r.aet_int;
		// Voltage conversions; a finishing conversion wins over a read clear.
		if (rd_vmon)
			st_nxt.regs[6][fdc_pkg::VMON_EOC] = 1'b0;
		if (st_r.conv != 8'd0) begin
			st_nxt.conv = st_r.conv - 8'd1;
			if (st_r.conv == 8'd1)
				st_nxt.regs[6][fdc_pkg::VMON_EOC] = 1'b1;
		end
		if ((flash_start && st_r.regs[6][fdc_pkg::VMON_ADC_EN]) ||
			wr_vmon_manual ||
			(rd_vmon && st_r.regs[6][fdc_pkg::VMON_MANUAL])) begin
			st_nxt.regs[6][fdc_pkg::VMON_EOC] = 1'b0;
			st_nxt.conv = 8'(fdc_pkg::CONV_CYC);
		end
		// Output mode resolution.
		st_nxt.mode_o = en[1:0];
		if (en[1:0] == fdc_pkg::MODE_FLASH) begin
			st_nxt.mode_o = flash_on ? fdc_pkg::MODE_FLASH :
				(st_r.flashing ? fdc_pkg::MODE_TORCH : fdc_pkg::MODE_OFF);
			if (st_r.therm_hold && flash_on)
				st_nxt.mode_o = c2[fdc_pkg::CFG2_THERM_SD] ? fdc_pkg::MODE_OFF
					: fdc_pkg::MODE_TORCH;
		end
		st_nxt.s1_o = en[fdc_pkg::EN_SRC_ONE];
		st_nxt.s2_o = en[fdc_pkg::EN_SRC_TWO];
		st_nxt.peak_o = en[fdc_pkg::EN_PRIV_PEAK];
		st_nxt.ind_o = en[fdc_pkg::EN_MSG] && !therm_on;
		st_nxt.blink_o = en[fdc_pkg::EN_MSG] && en[fdc_pkg::EN_BLINK] && !therm_on;
		st_nxt.therm_o = therm_on;
		st_nxt.sda_o = (st_nxt.st == S_READ) && st_nxt.shift[7];
		if (rst_in) begin
			st_nxt = '0;
			st_nxt.scl_s = 3'b111;
			st_nxt.sda_s = 3'b111;
			st_nxt.st = S_IDLE;
			st_nxt.after_ack = S_IDLE;
			st_nxt.regs = RESETS;
			st_nxt.s1_o = 1'b1;
			st_nxt.s2_o = 1'b1;
		end
	end
	always_ff @(posedge clock_in) begin
		st_r <= st_nxt;
	end
	assign link.sda_dev_oe = st_r.sda_oe;
	assign link.sda_dev_out = st_r.sda_o;
	assign led_mode_out = st_r.mode_o;
	assign current_source_one_out = st_r.s1_o;
	assign current_source_two_out = st_r.s2_o;
	assign privacy_peak_out = st_r.peak_o;
	assign indicator_on_out = st_r.ind_o;
	assign indicator_blink_out = st_r.blink_o;
	assign thermistor_mode_out = st_r.therm_o;
endmodule : fdc_device

// File: design/fdc_master.sv
`timescale 1ns/1ns
module fdc_master #(
	parameter int HALF_CYC = fdc_pkg::SCL_HALF_CYC
) (
	// Clock and reset
	input  wire logic       clock_in,
	input  wire logic       rst_in,
	// Link
	fdc_link_if.master      link,
	// Command
	input  wire logic       req_in,
	input  wire logic       read_in,
	input  wire logic [7:0] reg_in,
	input  wire logic [7:0] data_in,
	output logic            busy_out,
	output logic            done_out,
	output logic            nack_out,
	output logic [7:0]      data_out
);
	typedef enum {M_IDLE, M_START, M_BIT, M_ACK, M_RSTART, M_STOP}
		fdc_mst_st_type;
	typedef struct packed {
		logic [1:0]  sda_s;
		fdc_mst_st_type st;
		logic [1:0]  phase;
		logic [15:0] cnt;
		logic [1:0]  byte_no;
		logic [3:0]  bits;
		logic [7:0]  shift;
		logic        rd;
		logic [7:0]  rg;
		logic [7:0]  dat;
		logic        scl;
		logic        sda_low;
		logic        busy;
		logic        done;
		logic        nack;
		logic [7:0]  rdata;
	} fdc_mst_state_type;
	fdc_mst_state_type m_r, m_nxt;
	logic tick, rx_phase;
	always_comb begin
		m_nxt = m_r;
		m_nxt.sda_s = {m_r.sda_s[0], link.sda};
		m_nxt.done = 1'b0;
		tick = m_r.cnt == 16'(HALF_CYC - 1);
		m_nxt.cnt = tick ? 16'd0 : m_r.cnt + 16'd1;
		rx_phase = m_r.rd && m_r.byte_no == 2'd3;
		case (m_r.st)
			M_IDLE: begin
				m_nxt.cnt = 16'd0;
				if (req_in) begin
					m_nxt.busy = 1'b1;
					m_nxt.nack = 1'b0;
					m_nxt.rd = read_in;
					m_nxt.rg = reg_in;
					m_nxt.dat = data_in;
					m_nxt.st = M_START;
					m_nxt.phase = 2'd0;
				end
			end
			M_START: if (tick) begin
				m_nxt.phase = m_r.phase + 2'd1;
				if (m_r.phase == 2'd0)
					m_nxt.sda_low = 1'b1;
				else begin
					m_nxt.scl = 1'b0;
					m_nxt.st = M_BIT;
					m_nxt.phase = 2'd0;
					m_nxt.bits = 4'd0;
					m_nxt.shift = {fdc_pkg::SLAVE_ADDR,
						m_r.byte_no == 2'd2};
					m_nxt.sda_low = !fdc_pkg::SLAVE_ADDR[6];
				end
			end
			M_BIT: if (tick) begin
				if (!m_r.scl)
					m_nxt.scl = 1'b1;
				else begin
					m_nxt.scl = 1'b0;
					m_nxt.shift = {m_r.shift[6:0], m_r.sda_s[1]};
					m_nxt.bits = m_r.bits + 4'd1;
					if (m_r.bits == 4'd7) begin
						m_nxt.st = M_ACK;
						m_nxt.sda_low = 1'b0;
						if (rx_phase)
							m_nxt.rdata = {m_r.shift[6:0], m_r.sda_s[1]};
					end else
						m_nxt.sda_low = rx_phase ? 1'b0 : !m_r.shift[6];
				end
			end
			M_ACK: if (tick) begin
				if (!m_r.scl)
					m_nxt.scl = 1'b1;
				else begin
					m_nxt.scl = 1'b0;
					m_nxt.bits = 4'd0;
					if (m_r.sda_s[1] && !rx_phase) begin
						m_nxt.nack = 1'b1;
						m_nxt.sda_low = 1'b1;
						m_nxt.st = M_STOP;
					end else if (rx_phase || (!m_r.rd && m_r.byte_no == 2'd2)) begin
						m_nxt.sda_low = 1'b1;
						m_nxt.st = M_STOP;
					end else if (m_r.rd && m_r.byte_no == 2'd1) begin
						m_nxt.byte_no = 2'd2;
						m_nxt.sda_low = 1'b0;
						m_nxt.st = M_RSTART;
					end else begin
						m_nxt.byte_no = m_r.byte_no + 2'd1;
						m_nxt.shift = m_r.byte_no == 2'd0 ? m_r.rg : m_r.dat;
						// In the read data byte the master lets go of the wire.
						m_nxt.sda_low = m_r.byte_no == 2'd0 ? !m_r.rg[7] :
							(!m_r.rd && !m_r.dat[7]);
						m_nxt.st = M_BIT;
					end
				end
			end
			M_RSTART: if (tick) begin
				m_nxt.scl = 1'b1;
				m_nxt.st = M_START;
				m_nxt.phase = 2'd0;
			end
			M_STOP: if (tick) begin
				m_nxt.phase = m_r.phase + 2'd1;
				if (m_r.phase == 2'd0)
					m_nxt.scl = 1'b1;
				else begin
					m_nxt.sda_low = 1'b0;
					m_nxt.st = M_IDLE;
					m_nxt.busy = 1'b0;
					m_nxt.done = 1'b1;
					m_nxt.byte_no = 2'd0;
					m_nxt.phase = 2'd0;
				end
			end
			default: m_nxt.st = M_IDLE;
		endcase
		if (rst_in) begin
			m_nxt = '0;
			m_nxt.st = M_IDLE;
			m_nxt.scl = 1'b1;
			m_nxt.sda_s = 2'b11;
		end
	end
	always_ff @(posedge clock_in) begin
		m_r <= m_nxt;
	end
	assign link.scl = m_r.scl;
	assign link.sda_master_out = 1'b0;
	assign link.sda_master_oe = m_r.sda_low;
	assign busy_out = m_r.busy;
	assign done_out = m_r.done;
	assign nack_out = m_r.nack;
	assign data_out = m_r.rdata;
endmodule : fdc_master

// File: bench/fdc_checker.sv
`timescale 1ns/1ns
module fdc_checker (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// Link wires
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_master_out,
	input wire logic sda_master_oe,
	input wire logic sda_dev_out,
	input wire logic sda_dev_oe
);
	logic       scl_q_r;
	logic       sda_q_r;
	logic       busy_r;
	logic [1:0] starts_r;
	logic [5:0] rises_r;
	logic       start_ev;
	logic       stop_ev;

	// Start and stop need clock high on both samples, so a data bit
	// changing around a clock edge is never taken for either.
	assign start_ev = scl && scl_q_r && sda_q_r && !sda;
	assign stop_ev  = scl && scl_q_r && !sda_q_r && sda;

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			scl_q_r  <= 1'b1;
			sda_q_r  <= 1'b1;
			busy_r   <= 1'b0;
			starts_r <= 2'b00;
			rises_r  <= 6'h00;
		end else begin
			scl_q_r <= scl;
			sda_q_r <= sda;
			if (start_ev) begin
				busy_r   <= 1'b1;
				starts_r <= starts_r + 2'b01;
				rises_r  <= 6'h00;
			end else if (stop_ev) begin
				busy_r   <= 1'b0;
				starts_r <= 2'b00;
			end else if (scl && !scl_q_r && rises_r != 6'h3f) begin
				rises_r <= rises_r + 6'h01;
			end
		end
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);

	a_idle_reset: assert property (
		$fell(rst_in) |-> scl && !sda_master_oe && !sda_dev_oe)
		else $error("link not idle after reset");
	a_bus_free: assert property (
		!busy_r |-> scl && !sda_dev_oe)
		else $error("free bus not left idle");
	a_dev_steady: assert property (
		scl && scl_q_r |-> $stable(sda_dev_oe))
		else $error("device changed data while clock high");
	a_addr_msb: assert property (
		$rose(scl) && busy_r && rises_r < 7
		|-> sda == fdc_pkg::SLAVE_ADDR[6 - rises_r])
		else $error("address bit wrong");
	a_dir_bit: assert property (
		$rose(scl) && busy_r && rises_r == 7 |-> sda == (starts_r == 2'd2))
		else $error("direction bit wrong");
	a_quiet_addr: assert property (
		$rose(scl) && rises_r < 8 |-> !sda_dev_oe)
		else $error("device drove during address byte");
	a_ack_ninth: assert property (
		$rose(scl) && (rises_r == 8 || (starts_r == 2'd1 &&
		(rises_r == 17 || rises_r == 26)))
		|-> (sda_dev_oe && !sda_master_oe && !sda) [*3])
		else $error("byte not acknowledged");
	a_nack_read: assert property (
		$rose(scl) && starts_r == 2'd2 && rises_r == 17
		|-> !sda_dev_oe && sda)
		else $error("read not ended by not-acknowledge");

	c_write: cover property (stop_ev && starts_r == 2'd1);
	c_read: cover property (stop_ev && starts_r == 2'd2);
	c_rstart: cover property (start_ev && busy_r);
endmodule : fdc_checker

// File: bench/testbench.sv
`timescale 1ns/1ns
module testbench;
	localparam int FLASH = 200;
	logic        clock_in = 1'b0;
	logic        rst_in   = 1'b1;
	logic        req_in   = 1'b0;
	logic        read_in  = 1'b0;
	logic [7:0]  reg_in   = 8'h00;
	logic [7:0]  data_in  = 8'h00;
	logic        trig     = 1'b0;
	logic        sync     = 1'b0;
	logic        trip     = 1'b0;
	logic        busy_out, done_out, nack_out;
	logic [7:0]  data_out;
	logic [1:0]  mode;
	logic        src_one, src_two, peak, ind_on, ind_blink, therm;
	logic [31:0] seed     = 32'h0000_c1a9;
	logic [7:0]  mdl [logic [7:0]];
	int          error_cnt   = 0;
	int          checks_done = 0;
	logic [7:0]  adr [16] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20,
		8'h30, 8'h31, 8'h80, 8'h81, 8'ha0, 8'hb0, 8'hc0, 8'hd0, 8'he0, 8'hf0};
	logic [7:0]  rst [16] = '{8'h18, 8'h58, 8'h00, 8'h00, 8'hf8, 8'h80,
		8'h80, 8'h90, 8'hc0, 8'h00, 8'h52, 8'hdd, 8'hef, 8'h00, 8'h6b, 8'he0};

	always #2 clock_in = ~clock_in;

	fdc_link_if link ();
	fdc_master #(.HALF_CYC(10)) i_fdc_master (.clock_in(clock_in),
		.rst_in(rst_in), .link(link.master), .req_in(req_in),
		.read_in(read_in), .reg_in(reg_in), .data_in(data_in),
		.busy_out(busy_out), .done_out(done_out), .nack_out(nack_out),
		.data_out(data_out));
	fdc_device #(.DEGLITCH_CYC(20), .FLASH_CYC(FLASH)) i_fdc_device (
		.clock_in(clock_in), .rst_in(rst_in), .link(link.device),
		.trigger_in(trig), .torch_sync_input_in(sync),
		.comparator_trip_in(trip), .led_mode_out(mode),
		.current_source_one_out(src_one), .current_source_two_out(src_two),
		.privacy_peak_out(peak), .indicator_on_out(ind_on),
		.indicator_blink_out(ind_blink), .thermistor_mode_out(therm));
	fdc_checker i_fdc_checker (.clock_in(clock_in), .rst_in(rst_in),
		.scl(link.scl), .sda(link.sda), .sda_master_out(link.sda_master_out),
		.sda_master_oe(link.sda_master_oe), .sda_dev_out(link.sda_dev_out),
		.sda_dev_oe(link.sda_dev_oe));

	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : rnd

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(negedge clock_in);
	endtask : tick

	// Returns on a falling edge so callers may drive pins right away.
	task automatic xfer(input logic rd, input logic [7:0] a,
		input logic [7:0] d);
		int n;
		@(negedge clock_in);
		req_in  = 1'b1;
		read_in = rd;
		reg_in  = a;
		data_in = d;
		@(negedge clock_in);
		req_in = 1'b0;
		chk("busy", 8'h01, {7'h00, busy_out});
		for (n = 0; n < 2000 && done_out !== 1'b1; n++)
			@(posedge clock_in) #1;
		chk("done", 8'h01, {7'h00, done_out});
		chk("idle", 8'h00, {7'h00, busy_out});
		chk("nack", 8'h00, {7'h00, nack_out});
		if (!rd && mdl.exists(a) && a != 8'hd0)
			mdl[a] = d;
		@(negedge clock_in);
	endtask : xfer

	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input logic [7:0] m);
		xfer(1'b1, a, 8'h00);
		chk($sformatf("reg %h", a), e & m, data_out & m);
	endtask : rd

	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	initial begin
		logic [7:0] v;
		repeat (5) @(posedge clock_in);
		@(negedge clock_in);
		rst_in = 1'b0;
		for (int i = 0; i < 16; i++)
			mdl[adr[i]] = rst[i];
		for (int i = 0; i < 16; i++)
			rd(adr[i], rst[i], 8'hff);
		rd(8'h55, 8'h00, 8'hff);
		$display("test reset values done");
		for (int i = 1; i < 13; i++)
			if (i != 6)
				xfer(1'b0, adr[i], rnd());
		xfer(1'b0, 8'hd0, 8'hff);
		xfer(1'b0, 8'h55, 8'hff);
		for (int i = 1; i < 14; i++)
			if (i != 6)
				rd(adr[i], mdl[adr[i]], 8'hff);
		$display("test register access done");
		for (int m = 0; m < 3; m++) begin
			v = rnd();
			v[1:0] = m[1:0];
			xfer(1'b0, 8'h10, v);
			chk("pins", {v[7] & v[6], v[6], 1'b0, v[4:2], v[1:0]},
				{ind_blink, ind_on, therm, src_two, src_one, peak,
				mode});
		end
		rd(8'h10, v, 8'hff);
		$display("test enable pins done");
		xfer(1'b0, 8'h30, 8'h80);
		rd(8'h30, 8'hc0, 8'he0);
		rd(8'h30, 8'hc0, 8'he0);
		xfer(1'b0, 8'h30, 8'h20);
		rd(8'h30, 8'h60, 8'he0);
		rd(8'h30, 8'h20, 8'he0);
		xfer(1'b0, 8'h10, 8'h1b);
		trig = 1'b1;
		tick(6);
		chk("mode", 8'h03, {6'h00, mode});
		tick(FLASH);
		chk("mode", 8'h00, {6'h00, mode});
		trig = 1'b0;
		rd(8'h10, 8'h18, 8'hff);
		rd(8'hd0, 8'h01, 8'h09);
		rd(8'hd0, 8'h00, 8'hff);
		rd(8'h30, 8'h60, 8'he0);
		xfer(1'b0, 8'h10, 8'h1b);
		trig = 1'b1;
		tick(6);
		trig = 1'b0;
		tick(6);
		chk("level", 8'h00, {6'h00, mode});
		$display("test flash and conversion done");
		xfer(1'b0, 8'he0, 8'h7b);
		for (int k = 0; k < 2; k++) begin
			xfer(1'b0, 8'hf0, k ? 8'he2 : 8'he0);
			xfer(1'b0, 8'h10, 8'h5b);
			trig = 1'b1;
			tick(6);
			chk("therm", 8'h23, {2'b00, therm, ind_on, 2'b00, mode});
			trip = 1'b1;
			tick(10);
			trip = 1'b0;
			tick(10);
			chk("glitch", 8'h03, {6'h00, mode});
			trip = 1'b1;
			tick(30);
			chk("trip", k ? 8'h00 : 8'h02, {6'h00, mode});
			trig = 1'b0;
			rd(8'hd0, 8'h08, 8'h08);
			xfer(1'b0, 8'h10, 8'h1b);
			trig = 1'b1;
			tick(6);
			chk("held", 8'h00, {7'h00, mode == 2'b11});
			trip = 1'b0;
			trig = 1'b0;
			xfer(1'b1, 8'hd0, 8'h00);
			xfer(1'b0, 8'h10, 8'h1b);
			trig = 1'b1;
			tick(6);
			chk("reenter", 8'h03, {6'h00, mode});
			tick(FLASH);
			trig = 1'b0;
		end
		$display("test thermistor done");
		xfer(1'b0, 8'he0, 8'h6b);
		xfer(1'b0, 8'hf0, 8'he4);
		sync = 1'b1;
		xfer(1'b0, 8'h10, 8'h1b);
		trig = 1'b1;
		tick(FLASH + 100);
		chk("aet", 8'h02, {6'h00, mode});
		sync = 1'b0;
		trig = 1'b0;
		xfer(1'b0, 8'h10, 8'h1b);
		trig = 1'b1;
		tick(6);
		sync = 1'b1;
		tick(6);
		chk("aet", 8'h02, {6'h00, mode});
		tick(FLASH);
		chk("aet", 8'h00, {6'h00, mode});
		$display("test external torch done");
		wrap_up();
	end

	// About twice the expected run, so a slow link still finishes.
	initial begin
		#400_000;
		error_cnt++;
		$display("ERROR watchdog expected finish seen timeout");
		wrap_up();
	end
endmodule : testbench
